// file: src/sfc_pkg.sv
package sfc_pkg;
	localparam int DATA_W = 8;
	localparam int ADDR_W = 16;
	localparam int CNT_W  = 17;
	localparam int REG_AW = 4;
	localparam int REG_DW = 32;
	// Buffer length: 512 words shifted left by the length select (0..7 gives 512..64K)
	localparam logic [CNT_W-1:0] MIN_LEN = 17'h00200;
	localparam int LSEL_W = 3;
	// ==========================================================
	// Register offsets
	localparam logic [REG_AW-1:0] CTRL_OFS   = 4'h0;
	localparam logic [REG_AW-1:0] STAT_OFS   = 4'h4;
	localparam logic [REG_AW-1:0] EVENT_OFS  = 4'h8;
	localparam logic [REG_AW-1:0] MASK_OFS   = 4'hC;
	// ==========================================================
	// Control fields
	localparam int CTRL_LSEL_LSB = 0;
	localparam int CTRL_RPRIO    = 4;
	localparam int CTRL_WEN      = 5;
	localparam int CTRL_REN      = 6;
	localparam logic [6:0] CTRL_RESET = 7'h67;
	// Status and event fields share one layout
	localparam int FLAG_FULL   = 0;
	localparam int FLAG_EMPTY  = 1;
	localparam int FLAG_ALMOST = 2;
	localparam int FLAG_HALF   = 3;
	localparam int FLAG_W      = 4;
	localparam int STAT_CNT_LSB = 8;
	localparam logic [FLAG_W-1:0] MASK_RESET = 4'h0;
	// Almost flag within one eighth of either end
	localparam int ALMOST_SHIFT = 3;
	// ==========================================================
	// Controller sequence
	typedef enum logic [2:0] {
		SFC_IDLE, SFC_WCAP, SFC_WRAM1, SFC_WRAM2, SFC_RRAM1, SFC_RRAM2, SFC_RDONE
	} sfc_state_type;
endpackage : sfc_pkg

// file: src/sfc_link_if.sv
`timescale 1ns/1ps
`default_nettype none
interface sfc_link_if;
	import sfc_pkg::*;
	logic                write_request_n;
	logic                write_ready_out;
	logic                write_register_strobe;
	logic [DATA_W-1:0]   write_data;
	logic                read_request_n;
	logic                read_ready_out;
	logic                read_register_strobe;
	logic [DATA_W-1:0]   read_data;
	logic [ADDR_W-1:0]   ram_addr;
	logic                ram_we_n;
	logic                ram_oe_n;
	logic [DATA_W-1:0]   ram_wdata;
	logic [DATA_W-1:0]   ram_rdata;

	modport ctl (
		input  write_request_n, write_data, read_request_n, ram_rdata,
		output write_ready_out, write_register_strobe, read_ready_out, read_register_strobe,
		output read_data, ram_addr, ram_we_n, ram_oe_n, ram_wdata
	);
	modport sub (
		output write_request_n, write_data, read_request_n, ram_rdata,
		input  write_ready_out, write_register_strobe, read_ready_out, read_register_strobe,
		input  read_data, ram_addr, ram_we_n, ram_oe_n, ram_wdata
	);
endinterface : sfc_link_if
`default_nettype wire

// file: src/sfc_subsys.sv
`timescale 1ns/1ps
`default_nettype none
// Writing and reading subsystems plus the static RAM array, all on clk_sys
module sfc_subsys (
	input  wire logic                   clk_sys,
	input  wire logic                   rstn,
	sfc_link_if.sub                     link,
	input  wire logic [sfc_pkg::DATA_W-1:0] push_data,
	input  wire logic                   push_valid,
	output logic                        push_ready,
	output logic [sfc_pkg::DATA_W-1:0]  pop_data,
	output logic                        pop_valid,
	input  wire logic                   pop_ack
);
	import sfc_pkg::*;

	logic [DATA_W-1:0] mem [0:(1<<ADDR_W)-1];
	logic [DATA_W-1:0] ram_rdata_q;
	logic              wbusy_q;
	logic              write_request_n_n_q;
	logic [DATA_W-1:0] wdata_q;
	logic              rbusy_q;
	logic              rreq_n_q;
	logic [DATA_W-1:0] pop_data_q;
	logic              pop_valid_q;
	logic              push_ready_q;

	// ==========================================================
	// RAM array
	always_ff @(posedge clk_sys) begin
		if (!link.ram_we_n)
			mem[link.ram_addr] <= link.ram_wdata;
		ram_rdata_q <= mem[link.ram_addr];
	end
	assign link.ram_rdata = link.ram_oe_n ? '0 : ram_rdata_q;

	// ==========================================================
	// Writer
	wire w_start = push_valid & push_ready_q & link.write_ready_out;

	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			wbusy_q      <= 1'b0;
			write_request_n_n_q     <= 1'b1;
			wdata_q      <= '0;
			push_ready_q <= 1'b0;
		end else begin
			push_ready_q <= ~wbusy_q & ~w_start;
			if (w_start) begin
				wbusy_q  <= 1'b1;
				write_request_n_n_q <= 1'b0;
				wdata_q  <= push_data;
			end else if (wbusy_q && !link.write_ready_out && link.write_register_strobe && !write_request_n_n_q) begin
				// Strobe back high means the word is captured; data may now go
				write_request_n_n_q <= 1'b1;
			end else if (wbusy_q && write_request_n_n_q && link.write_ready_out) begin
				wbusy_q <= 1'b0;
			end
		end
	end
	assign link.write_request_n = write_request_n_n_q;
	assign link.write_data      = wdata_q;
	assign push_ready           = push_ready_q;

	// ==========================================================
	// Reader: fetches one word whenever it is not busy, its output slot is free and read_ready_out is high
	wire r_start = ~rbusy_q & ~pop_valid_q & link.read_ready_out;

	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			rbusy_q     <= 1'b0;
			rreq_n_q    <= 1'b1;
			pop_data_q  <= '0;
			pop_valid_q <= 1'b0;
		end else begin
			if (r_start) begin
				rbusy_q  <= 1'b1;
				rreq_n_q <= 1'b0;
			end else if (rbusy_q && !rreq_n_q && !link.read_ready_out && link.read_register_strobe) begin
				pop_data_q  <= link.read_data;
				pop_valid_q <= 1'b1;
				rreq_n_q    <= 1'b1;
			end else if (rbusy_q && rreq_n_q) begin
				rbusy_q <= 1'b0;
			end
			if (pop_ack && pop_valid_q)
				pop_valid_q <= 1'b0;
		end
	end
	assign link.read_request_n = rreq_n_q;
	assign pop_data            = pop_data_q;
	assign pop_valid           = pop_valid_q;
endmodule : sfc_subsys
`default_nettype wire

// file: src/sfc_controller.sv
`timescale 1ns/1ps
`default_nettype none
module sfc_controller (
	input  wire logic                        clk_sys,
	input  wire logic                        rstn,
	sfc_link_if.ctl                          link,
	input  wire logic [sfc_pkg::REG_AW-1:0]  reg_addr,
	input  wire logic [sfc_pkg::REG_DW-1:0]  reg_wdata,
	input  wire logic                        reg_wr,
	input  wire logic                        reg_rd,
	output logic [sfc_pkg::REG_DW-1:0]       reg_rdata,
	output logic                             irq
);
	import sfc_pkg::*;

	function automatic logic [CNT_W-1:0] len_of(input logic [LSEL_W-1:0] sel);
		len_of = MIN_LEN << sel;
	endfunction : len_of

	sfc_state_type      state_q;
	logic [1:0]         wsync_q;
	logic [1:0]         rsync_q;
	logic [6:0]         ctrl_q;
	logic [FLAG_W-1:0]  mask_q;
	logic [FLAG_W-1:0]  event_q;
	logic [FLAG_W-1:0]  flags_q;
	logic [CNT_W-1:0]   count_q;
	logic [ADDR_W-1:0]  waddr_q;
	logic [ADDR_W-1:0]  raddr_q;
	logic [DATA_W-1:0]  wreg_q;
	logic [DATA_W-1:0]  rreg_q;
	logic               write_ready_out_q;
	logic               wstb_q;
	logic               rrdy_q;
	logic               rstb_q;
	logic [ADDR_W-1:0]  ram_addr_q;
	logic               ram_we_n_q;
	logic               ram_oe_n_q;
	logic [REG_DW-1:0]  reg_rdata_q;
	logic               irq_q;

	// ==========================================================
	// Request synchronizers
	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			wsync_q <= 2'h3;
			rsync_q <= 2'h3;
		end else begin
			wsync_q <= {wsync_q[0], link.write_request_n};
			rsync_q <= {rsync_q[0], link.read_request_n};
		end
	end
	wire write_request_n_n_s = wsync_q[1];
	wire rreq_n_s = rsync_q[1];

	// ==========================================================
	// Length, flags and arbitration
	wire [LSEL_W-1:0] lsel   = ctrl_q[CTRL_LSEL_LSB +: LSEL_W];
	wire [CNT_W-1:0]  len    = len_of(lsel);
	wire [ADDR_W-1:0] amask  = ADDR_W'(len - 17'h00001);
	wire [CNT_W-1:0]  margin = len >> ALMOST_SHIFT;
	wire              is_full  = count_q >= len;
	wire              is_empty = count_q == '0;
	wire [FLAG_W-1:0] flags_d;
	assign flags_d[FLAG_FULL]   = is_full;
	assign flags_d[FLAG_EMPTY]  = is_empty;
	assign flags_d[FLAG_ALMOST] = (count_q <= margin) || (count_q >= len - margin);
	assign flags_d[FLAG_HALF]   = count_q >= (len >> 1);

	wire w_en  = ctrl_q[CTRL_WEN];
	wire r_en  = ctrl_q[CTRL_REN];
	// A disabled side never wins, so the other side owns the buffer outright
	wire w_pend = ~write_request_n_n_s & write_ready_out_q & w_en;
	wire r_pend = ~rreq_n_s & rrdy_q & r_en;
	wire go_w   = w_pend & ~(r_pend & ctrl_q[CTRL_RPRIO]);
	wire go_r   = r_pend & ~go_w;
	wire idle   = state_q == SFC_IDLE;
	// Ready only after the previous request has been seen released
	wire write_ready_out_d = idle & ~go_w & ~go_r & w_en & write_request_n_n_s & ~is_full;
	wire rrdy_d = idle & ~go_w & ~go_r & r_en & rreq_n_s & ~is_empty;

	// ==========================================================
	// Transfer sequence
	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			state_q    <= SFC_IDLE;
			wstb_q     <= 1'b1;
			rstb_q     <= 1'b1;
			wreg_q     <= '0;
			rreg_q     <= '0;
			waddr_q    <= '0;
			raddr_q    <= '0;
			count_q    <= '0;
			ram_addr_q <= '0;
			ram_we_n_q <= 1'b1;
			ram_oe_n_q <= 1'b1;
		end else begin
			case (state_q)
				SFC_IDLE: begin
					if (go_w) begin
						wstb_q  <= 1'b0;
						state_q <= SFC_WCAP;
					end else if (go_r) begin
						rstb_q     <= 1'b0;
						ram_addr_q <= raddr_q;
						ram_oe_n_q <= 1'b0;
						state_q    <= SFC_RRAM1;
					end
				end
				SFC_WCAP: begin
					wstb_q     <= 1'b1;
					wreg_q     <= link.write_data;
					ram_addr_q <= waddr_q;
					ram_we_n_q <= 1'b0;
					state_q    <= SFC_WRAM1;
				end
				SFC_WRAM1: begin
					state_q <= SFC_WRAM2;
				end
				SFC_WRAM2: begin
					ram_we_n_q <= 1'b1;
					waddr_q    <= (waddr_q + 16'h0001) & amask;
					count_q    <= count_q + 17'h00001;
					state_q    <= SFC_IDLE;
				end
				SFC_RRAM1: begin
					state_q <= SFC_RRAM2;
				end
				SFC_RRAM2: begin
					rreg_q     <= link.ram_rdata;
					ram_oe_n_q <= 1'b1;
					raddr_q    <= (raddr_q + 16'h0001) & amask;
					count_q    <= count_q - 17'h00001;
					state_q    <= SFC_RDONE;
				end
				SFC_RDONE: begin
					rstb_q  <= 1'b1;
					state_q <= SFC_IDLE;
				end
				default: begin
					state_q <= SFC_IDLE;
				end
			endcase
		end
	end

	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			write_ready_out_q <= 1'b0;
			rrdy_q <= 1'b0;
		end else begin
			write_ready_out_q <= write_ready_out_d;
			rrdy_q <= rrdy_d;
		end
	end

	// ==========================================================
	// Register port
	wire sel_ctrl  = reg_addr == CTRL_OFS;
	wire sel_stat  = reg_addr == STAT_OFS;
	wire sel_event = reg_addr == EVENT_OFS;
	wire sel_mask  = reg_addr == MASK_OFS;
	wire [REG_DW-1:0] rd_mux;
	assign rd_mux = sel_ctrl  ? {25'h0000000, ctrl_q} :
	                sel_stat  ? {7'h00, count_q, 4'h0, flags_q} :
	                sel_event ? {28'h0000000, event_q} :
	                sel_mask  ? {28'h0000000, mask_q} : 32'h00000000;
	// A new flag edge wins over a clear by read in the same cycle
	wire [FLAG_W-1:0] rise  = flags_d & ~flags_q;
	wire [FLAG_W-1:0] clr   = (reg_rd && sel_event) ? {FLAG_W{1'b1}} : {FLAG_W{1'b0}};
	wire [FLAG_W-1:0] evt_d = (event_q & ~clr) | rise;

	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			ctrl_q      <= CTRL_RESET;
			mask_q      <= MASK_RESET;
			event_q     <= '0;
			flags_q     <= 4'h2;
			reg_rdata_q <= '0;
			irq_q       <= 1'b0;
		end else begin
			if (reg_wr && sel_ctrl)
				ctrl_q <= reg_wdata[6:0];
			if (reg_wr && sel_mask)
				mask_q <= reg_wdata[FLAG_W-1:0];
			flags_q     <= flags_d;
			event_q     <= evt_d;
			reg_rdata_q <= reg_rd ? rd_mux : '0;
			irq_q       <= |(evt_d & mask_q);
		end
	end

	assign link.write_ready_out       = write_ready_out_q;
	assign link.write_register_strobe = wstb_q;
	assign link.read_ready_out        = rrdy_q;
	assign link.read_register_strobe  = rstb_q;
	assign link.read_data             = rreg_q;
	assign link.ram_addr              = ram_addr_q;
	assign link.ram_we_n              = ram_we_n_q;
	assign link.ram_oe_n              = ram_oe_n_q;
	assign link.ram_wdata             = wreg_q;
	assign reg_rdata                  = reg_rdata_q;
	assign irq                        = irq_q;
endmodule : sfc_controller
`default_nettype wire

// file: tb/sfc_asserts.sv
`timescale 1ns/1ps
`default_nettype none
// ==========================================
// Handshake and RAM timing checks on the link
module sfc_asserts (
	input  wire logic                      clk_sys,
	input  wire logic                      rstn,
	input  wire logic                      write_request_n,
	input  wire logic                      write_ready_out,
	input  wire logic                      write_register_strobe,
	input  wire logic                      read_request_n,
	input  wire logic                      read_register_strobe,
	input  wire logic [sfc_pkg::DATA_W-1:0] read_data,
	input  wire logic [sfc_pkg::ADDR_W-1:0] ram_addr,
	input  wire logic                      ram_we_n,
	input  wire logic                      ram_oe_n,
	input  wire logic [sfc_pkg::DATA_W-1:0] ram_wdata
);
	import sfc_pkg::*;
	default clocking @(posedge clk_sys); endclocking
	default disable iff (!rstn);
	a_wstb_one: assert property ($fell(write_register_strobe) |=> write_register_strobe)
		else $error("write strobe low longer than one cycle");
	a_write_ready_out_drop: assert property ($fell(write_register_strobe) |-> !write_ready_out)
		else $error("write ready still high at strobe");
	// Two stages: the strobe may not react to a request younger than two edges
	a_req_sync: assert property ($fell(write_register_strobe) |-> $past(write_request_n, 2) == 1'b0)
		else $error("strobe fell before request was synchronized");
	a_we_two: assert property ($fell(ram_we_n) |=> !ram_we_n ##1 ram_we_n)
		else $error("ram write not two cycles");
	a_we_follows: assert property ($rose(write_register_strobe) |-> ##[0:1] $fell(ram_we_n))
		else $error("no ram write after capture");
	a_we_hold: assert property (!ram_we_n && $past(!ram_we_n) |-> $stable(ram_addr) && $stable(ram_wdata))
		else $error("ram address or data moved during write");
	a_ram_excl: assert property (ram_we_n || ram_oe_n)
		else $error("ram read and write at once");
	a_busy_write_ready_out: assert property (!ram_we_n |-> !write_ready_out)
		else $error("write ready high during ram write");
	a_rstb_len: assert property ($fell(read_register_strobe) |-> !ram_oe_n ##0 !read_register_strobe [*3]
		##1 read_register_strobe)
		else $error("read strobe timing wrong");
	a_rdata_hold: assert property ($rose(read_register_strobe) |=> $stable(read_data))
		else $error("read data moved after strobe rose");
	cover property ($fell(write_register_strobe));
	cover property ($fell(read_register_strobe));
	cover property (!write_request_n && !read_request_n);
endmodule : sfc_asserts
`default_nettype wire

// file: tb/sram_fifo_controller_bench.sv
`timescale 1ns/1ps
`default_nettype none
module sram_fifo_controller_bench;
	import sfc_pkg::*;
	logic              clk_sys = 1'b0;
	logic              rstn = 1'b0;
	logic [REG_AW-1:0] reg_addr = '0;
	logic [REG_DW-1:0] reg_wdata = '0, reg_rdata, v;
	logic              reg_wr = 1'b0, reg_rd = 1'b0, irq, push_valid = 1'b0, push_ready, pop_valid, pop_ack = 1'b0;
	logic [DATA_W-1:0] push_data = '0, pop_data;
	logic [ADDR_W-1:0] wa;
	logic              ok;
	int                fail_count = 0, n_checks = 0, cyc = 0;
	sfc_link_if link();
	sfc_controller sfc_controller_i (.clk_sys(clk_sys), .rstn(rstn), .link(link), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .irq(irq));
	sfc_subsys sfc_subsys_i (.clk_sys(clk_sys), .rstn(rstn), .link(link), .push_data(push_data),
		.push_valid(push_valid), .push_ready(push_ready), .pop_data(pop_data), .pop_valid(pop_valid), .pop_ack(pop_ack));
	sfc_asserts sfc_asserts_i (.clk_sys(clk_sys), .rstn(rstn), .write_request_n(link.write_request_n),
		.write_ready_out(link.write_ready_out), .write_register_strobe(link.write_register_strobe),
		.read_request_n(link.read_request_n), .read_register_strobe(link.read_register_strobe),
		.read_data(link.read_data), .ram_addr(link.ram_addr), .ram_we_n(link.ram_we_n),
		.ram_oe_n(link.ram_oe_n), .ram_wdata(link.ram_wdata));
	always #50 clk_sys = ~clk_sys;
	// ==========================================
	// Shared tasks
	task automatic chk(input string what, input logic [REG_DW-1:0] exp, input logic [REG_DW-1:0] got);
		n_checks++;
		if (got !== exp) begin
			fail_count++;
			$display("mismatch %s expected %h seen %h", what, exp, got);
		end
	endtask : chk
	task automatic wr(input logic [REG_AW-1:0] a, input logic [REG_DW-1:0] d);
		@(posedge clk_sys);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge clk_sys);
		reg_wr <= 1'b0;
	endtask : wr
	task automatic rd(input logic [REG_AW-1:0] a);
		@(posedge clk_sys);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge clk_sys);
		reg_rd <= 1'b0;
		#1 v = reg_rdata;
	endtask : rd
	// Offers one word; ok tells whether it was taken, wa the ram address it went to
	task automatic push(input logic [DATA_W-1:0] d, input int lim);
		int k;
		k = 0;
		@(posedge clk_sys);
		push_data <= d;
		push_valid <= 1'b1;
		do begin
			@(posedge clk_sys);
			k++;
		end while (!(push_ready === 1'b1 && link.write_ready_out === 1'b1) && k < lim);
		push_valid <= 1'b0;
		ok = (k < lim);
		k = 0;
		while (ok && link.ram_we_n !== 1'b0 && k < 20) begin
			@(posedge clk_sys);
			k++;
		end
		wa = link.ram_addr;
	endtask : push
	task automatic pop(input logic [DATA_W-1:0] e);
		int k;
		k = 0;
		do begin
			@(posedge clk_sys);
			k++;
		end while (pop_valid !== 1'b1 && k < 40);
		chk("pop data", {24'h000000, e}, {24'h000000, pop_data});
		pop_ack <= 1'b1;
		@(posedge clk_sys);
		pop_ack <= 1'b0;
	endtask : pop
	task automatic close_out;
		$display("checks %0d mismatches %0d", n_checks, fail_count);
		if (fail_count == 0 && n_checks > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask : close_out
	// ==========================================
	// Scenarios
	task automatic t_reset_regs;
		rd(CTRL_OFS);
		chk("ctrl reset", 32'h00000067, v);
		rd(STAT_OFS);
		chk("status reset", 32'h00000006, v);
		wr(4'h2, 32'hFFFFFFFF);
		rd(4'h2);
		chk("unmapped", 32'h00000000, v);
		chk("rdy empty", 0, link.read_ready_out);
		rd(EVENT_OFS);
	endtask : t_reset_regs
	// Fill a 512 buffer with the reader shut out, then drain it with the writer shut out
	task automatic t_fill_drain;
		wr(MASK_OFS, 32'h00000001);
		wr(CTRL_OFS, 32'h00000020);
		for (int i = 0; i < 512; i++) begin
			if (i == 64 || i == 65 || i == 256) begin
				repeat (4) @(posedge clk_sys);
				rd(STAT_OFS);
				chk("status", (i << 8) | (i == 64 ? 4 : i == 256 ? 8 : 0), v);
			end
			push(i[7:0], 40);
			chk("write addr", i, wa);
		end
		push(8'hEE, 30);
		chk("push when full", 0, ok);
		rd(STAT_OFS);
		chk("status full", 32'h0002000D, v);
		chk("irq full", 1, irq);
		rd(EVENT_OFS);
		chk("events", 32'h0000000D, v);
		repeat (3) @(posedge clk_sys);
		chk("irq clear", 0, irq);
		wr(MASK_OFS, 32'h00000000);
		wr(CTRL_OFS, 32'h00000040);
		repeat (4) @(posedge clk_sys);
		chk("write_ready_out disabled", 0, link.write_ready_out);
		for (int i = 0; i < 512; i++)
			pop(i[7:0]);
		repeat (6) @(posedge clk_sys);
		rd(STAT_OFS);
		chk("status empty", 32'h00000006, v);
		chk("rdy empty", 0, link.read_ready_out);
	endtask : t_fill_drain
	task automatic t_wrap;
		wr(CTRL_OFS, 32'h00000070);
		rd(CTRL_OFS);
		chk("ctrl read priority", 32'h00000070, v);
		push(8'hA5, 40);
		chk("wrap addr", 0, wa);
		pop(8'hA5);
	endtask : t_wrap
	always @(posedge clk_sys) begin
		cyc++;
		if (cyc == 40000) begin
			fail_count++;
			close_out;
		end
	end
	initial begin
		repeat (20) @(posedge clk_sys);
		rstn <= 1'b1;
		t_reset_regs;
		t_fill_drain;
		t_wrap;
		close_out;
	end
endmodule : sram_fifo_controller_bench
`default_nettype wire
